/* hw/fgrc_pkg.sv */
`default_nettype none
package fgrc_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] OFS_PIN_CAPABILITY = 8'h04;
	localparam logic [7:0] OFS_PIN_USE_SELECT = 8'h05;
	localparam logic [7:0] OFS_SENSORS_INSTALLED = 8'h06;
	localparam logic [7:0] OFS_ALARM_SPEED_OVERRIDE = 8'h07;
	localparam logic [7:0] OFS_HOTPLUG_SPEED_OVERRIDE = 8'h08;
	localparam logic [7:0] OFS_FULL_SPEED_OVERRIDE = 8'h09;
	// ==========================================
	// Reset values and field layout
	localparam logic [7:0] RST_PIN_CAPABILITY = 8'h7F;
	localparam logic [7:0] RST_OVERRIDE = 8'h00;
	localparam logic [2:0] RST_PIN_USE_LOW = 3'h7;
	localparam int POS_DIODE_A_LO = 3;
	localparam int POS_DIODE_B_LO = 5;
	localparam int POS_LOCAL_SENSOR = 0;
	localparam int NUM_FANS = 2;
	// ==========================================
	// Detection settle time after reset release
	localparam int DETECT_TIME_NS = 1000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int DETECT_CYCLES = (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ==========================================
	// Fan speed selections
	typedef enum logic [1:0]
	{
		FGRC_SPEED_NORMAL,
		FGRC_SPEED_ALARM,
		FGRC_SPEED_HOTPLUG,
		FGRC_SPEED_FULL
	} fgrc_speed_type;
endpackage
`default_nettype wire

/* hw/fgrc_sync.sv */
`default_nettype none
module fgrc_sync
	import fgrc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Level in and out
	input wire logic din,
	output logic dout
);
	logic meta_q;
	logic meta_d;
	logic out_q;
	logic out_d;

	always_comb
	begin
		meta_d = din;
		out_d = meta_q;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= 1'b0;
			out_q <= 1'b0;
		end
		else
		begin
			meta_q <= meta_d;
			out_q <= out_d;
		end
	end

	assign dout = out_q;
endmodule
`default_nettype wire

/* hw/fgrc_speed_sel.sv */
`default_nettype none
module fgrc_speed_sel
	import fgrc_pkg::*;
(
	// Requests for one fan
	input wire logic monitor_start,
	input wire logic alarm_req,
	input wire logic hotplug_req,
	input wire logic full_req,
	input wire logic hotplug_priority,
	// Chosen speed
	output fgrc_speed_type speed
);
	// Stopped monitoring outranks every override, full speed included
	always_comb
	begin
		if (!monitor_start)
			speed = FGRC_SPEED_ALARM; // see RL13
		else if (full_req)
			speed = FGRC_SPEED_FULL; // see RL14
		else if (alarm_req && hotplug_req)
			speed = hotplug_priority ? FGRC_SPEED_HOTPLUG : FGRC_SPEED_ALARM; // see RL12
		else if (hotplug_req)
			speed = FGRC_SPEED_HOTPLUG; // see RL10
		else if (alarm_req)
			speed = FGRC_SPEED_ALARM; // see RL9
		else
			speed = FGRC_SPEED_NORMAL;
	end
endmodule
`default_nettype wire

/* hw/fgrc_regs.sv */
// How it works
// RL1 - Pin capability reads 7Fh, read-only
// RL2 - Pin-use bits 0,1 reset 1, writable
// RL3 - Pin-use bit 2 resets 1, writable
// RL4 - First diode found clears pin-use bits 3,4
// RL5 - Second diode found clears pin-use bits 5,6
// RL6 - Unused bits read zero, ignore writes
// RL7 - Local sensor bit always reads one
// RL8 - Remote sensor bits show power-up detection
// RL9 - Alarm override bits reset 0, force alarm
// RL10 - Hot-plug override bits force hot-plug speed
// RL11 - Full override bits force full speed
// RL12 - Priority bit picks hot-plug over alarm
// RL13 - Monitoring stopped means alarm speed
// RL14 - Full speed beats alarm and hot-plug
`default_nettype none
module fgrc_regs
	import fgrc_pkg::*;
#(
	parameter int NFANS = NUM_FANS
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register access from the serial bus engine
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Diode sense pins
	input wire logic remote_diode_first,
	input wire logic remote_diode_second,
	// Control from the configuration and fan status registers
	input wire logic monitor_start,
	input wire logic [NFANS-1:0] hotplug_priority,
	// Fan speed selection per fan, two bits each
	output logic [2*NFANS-1:0] fan_speed
);
	// ==========================================
	// Pin synchronisers
	logic diode_a_sync;
	logic diode_b_sync;

	fgrc_sync u_sync_a
	(
		.mclk(mclk),
		.rst(rst),
		.din(remote_diode_first),
		.dout(diode_a_sync)
	);

	fgrc_sync u_sync_b
	(
		.mclk(mclk),
		.rst(rst),
		.din(remote_diode_second),
		.dout(diode_b_sync)
	);

	// ==========================================
	// Power-up detection
	typedef enum logic [1:0]
	{
		FGRC_DET_WAIT,
		FGRC_DET_LATCH,
		FGRC_DET_DONE
	} fgrc_det_type;

	fgrc_det_type det_q;
	fgrc_det_type det_d;
	logic [7:0] det_cnt_q;
	logic [7:0] det_cnt_d;
	logic remote_sensor_a_present_q;
	logic remote_sensor_a_present_d;
	logic remote_sensor_b_present_q;
	logic remote_sensor_b_present_d;

	// Detection waits for the synchronisers and the diode bias to settle
	always_comb
	begin
		det_d = det_q;
		det_cnt_d = det_cnt_q;
		remote_sensor_a_present_d = remote_sensor_a_present_q;
		remote_sensor_b_present_d = remote_sensor_b_present_q;
		case (det_q)
			FGRC_DET_WAIT:
			begin
				if (det_cnt_q == 8'(DETECT_CYCLES - 1))
					det_d = FGRC_DET_LATCH;
				else
					det_cnt_d = det_cnt_q + 8'h01;
			end
			FGRC_DET_LATCH:
			begin
				remote_sensor_a_present_d = diode_a_sync; // see RL8
				remote_sensor_b_present_d = diode_b_sync; // see RL8
				det_d = FGRC_DET_DONE;
			end
			FGRC_DET_DONE:
				det_d = FGRC_DET_DONE;
			default:
				det_d = FGRC_DET_WAIT;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			det_q <= FGRC_DET_WAIT;
			det_cnt_q <= 8'h00;
			remote_sensor_a_present_q <= 1'b0;
			remote_sensor_b_present_q <= 1'b0;
		end
		else
		begin
			det_q <= det_d;
			det_cnt_q <= det_cnt_d;
			remote_sensor_a_present_q <= remote_sensor_a_present_d;
			remote_sensor_b_present_q <= remote_sensor_b_present_d;
		end
	end

	// ==========================================
	// Writable registers
	logic [6:0] pin_use_q;
	logic [6:0] pin_use_d;
	logic [NFANS-1:0] alarm_q;
	logic [NFANS-1:0] alarm_d;
	logic [NFANS-1:0] hotplug_q;
	logic [NFANS-1:0] hotplug_d;
	logic [NFANS-1:0] full_q;
	logic [NFANS-1:0] full_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	always_comb
	begin
		pin_use_d = pin_use_q;
		alarm_d = alarm_q;
		hotplug_d = hotplug_q;
		full_d = full_q;
		// A software write in the latch cycle still wins over the detected default
		if (det_q == FGRC_DET_LATCH)
		begin
			pin_use_d[POS_DIODE_A_LO +: 2] = {2{~diode_a_sync}}; // see RL4
			pin_use_d[POS_DIODE_B_LO +: 2] = {2{~diode_b_sync}}; // see RL5
		end
		if (reg_wr)
		begin
			case (reg_addr)
				OFS_PIN_USE_SELECT:
					pin_use_d = reg_wdata[6:0]; // see RL2 see RL3 see RL4 see RL5
				OFS_ALARM_SPEED_OVERRIDE:
					alarm_d = reg_wdata[NFANS-1:0]; // see RL9
				OFS_HOTPLUG_SPEED_OVERRIDE:
					hotplug_d = reg_wdata[NFANS-1:0]; // see RL10
				OFS_FULL_SPEED_OVERRIDE:
					full_d = reg_wdata[NFANS-1:0]; // see RL11
				default:
					pin_use_d = pin_use_d;
			endcase
		end
	end

	// ==========================================
	// Read mux, unused bits read zero
	always_comb
	begin
		rdata_d = rdata_q;
		if (reg_rd)
		begin
			rdata_d = 8'h00; // see RL6
			case (reg_addr)
				OFS_PIN_CAPABILITY:
					rdata_d = RST_PIN_CAPABILITY; // see RL1
				OFS_PIN_USE_SELECT:
					rdata_d = {1'b0, pin_use_q};
				OFS_SENSORS_INSTALLED:
				begin
					rdata_d[POS_LOCAL_SENSOR] = 1'b1; // see RL7
					rdata_d[2:1] = {remote_sensor_b_present_q, remote_sensor_a_present_q};
				end
				OFS_ALARM_SPEED_OVERRIDE:
					rdata_d[NFANS-1:0] = alarm_q;
				OFS_HOTPLUG_SPEED_OVERRIDE:
					rdata_d[NFANS-1:0] = hotplug_q;
				OFS_FULL_SPEED_OVERRIDE:
					rdata_d[NFANS-1:0] = full_q;
				default:
					rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pin_use_q <= {4'h0, RST_PIN_USE_LOW} | 7'h78;
			alarm_q <= RST_OVERRIDE[NFANS-1:0];
			hotplug_q <= RST_OVERRIDE[NFANS-1:0];
			full_q <= RST_OVERRIDE[NFANS-1:0];
			rdata_q <= 8'h00;
		end
		else
		begin
			pin_use_q <= pin_use_d;
			alarm_q <= alarm_d;
			hotplug_q <= hotplug_d;
			full_q <= full_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// ==========================================
	// Fan speed choice, one selector per fan
	logic [2*NFANS-1:0] speed_d;
	logic [2*NFANS-1:0] speed_q;

	for (genvar f = 0; f < NFANS; f++)
	begin : g_fan
		fgrc_speed_sel u_sel
		(
			.monitor_start(monitor_start),
			.alarm_req(alarm_q[f]),
			.hotplug_req(hotplug_q[f]),
			.full_req(full_q[f]),
			.hotplug_priority(hotplug_priority[f]),
			.speed(speed_d[2*f +: 2])
		);
	end

	// Reset shows alarm speed: monitoring has not started yet
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			speed_q <= {NFANS{FGRC_SPEED_ALARM}};
		else
			speed_q <= speed_d;
	end

	assign fan_speed = speed_q;

	// ==========================================
	// Checks
	a_cap_read: assert property (@(posedge mclk) disable iff (rst) // see RL1
		reg_rd && reg_addr == OFS_PIN_CAPABILITY |=> reg_rdata == 8'h7F)
		else $error("capability read wrong");
	a_use_top_zero: assert property (@(posedge mclk) disable iff (rst) // see RL6
		reg_rd && reg_addr == OFS_PIN_USE_SELECT |=> reg_rdata[7] == 1'b0)
		else $error("pin use bit 7 not zero");
	a_local_sensor: assert property (@(posedge mclk) disable iff (rst) // see RL7
		reg_rd && reg_addr == OFS_SENSORS_INSTALLED |=> reg_rdata[0] && reg_rdata[7:3] == 5'h00)
		else $error("sensor register bits wrong");
	a_pin_use_wr: assert property (@(posedge mclk) disable iff (rst) // see RL2
		reg_wr && reg_addr == OFS_PIN_USE_SELECT |=> pin_use_q == $past(reg_wdata[6:0]))
		else $error("pin use write lost");
	a_diode_a_det: assert property (@(posedge mclk) disable iff (rst) // see RL4
		det_q == FGRC_DET_LATCH && !reg_wr
		|=> pin_use_q[4:3] == {2{~remote_sensor_a_present_q}})
		else $error("first diode default wrong");
	a_diode_b_det: assert property (@(posedge mclk) disable iff (rst) // see RL5
		det_q == FGRC_DET_LATCH && !reg_wr
		|=> pin_use_q[6:5] == {2{~remote_sensor_b_present_q}})
		else $error("second diode default wrong");
	a_sense_hold: assert property (@(posedge mclk) disable iff (rst) // see RL8
		det_q == FGRC_DET_DONE |=> $stable(remote_sensor_a_present_q))
		else $error("detection changed after power-up");
	a_full_wins: assert property (@(posedge mclk) disable iff (rst) // see RL14
		monitor_start && full_q[0] |=> fan_speed[1:0] == FGRC_SPEED_FULL)
		else $error("full speed not chosen");
	a_stop_alarm: assert property (@(posedge mclk) disable iff (rst) // see RL13
		!monitor_start |=> fan_speed == {NFANS{FGRC_SPEED_ALARM}})
		else $error("alarm speed not forced");
	a_priority: assert property (@(posedge mclk) disable iff (rst) // see RL12
		monitor_start && !full_q[0] && alarm_q[0] && hotplug_q[0] && hotplug_priority[0]
		|=> fan_speed[1:0] == FGRC_SPEED_HOTPLUG)
		else $error("hot-plug priority ignored");
	a_alarm_wr: assert property (@(posedge mclk) disable iff (rst) // see RL9
		reg_wr && reg_addr == OFS_ALARM_SPEED_OVERRIDE ##1 !reg_wr
		|=> alarm_q == $past(reg_wdata[NFANS-1:0], 2))
		else $error("alarm override lost");
	a_full_wr: assert property (@(posedge mclk) disable iff (rst) // see RL11
		reg_wr && reg_addr == OFS_FULL_SPEED_OVERRIDE |=> full_q == $past(reg_wdata[NFANS-1:0]))
		else $error("full override lost");
	a_hot_wr: assert property (@(posedge mclk) disable iff (rst) // see RL10
		reg_wr && reg_addr == OFS_HOTPLUG_SPEED_OVERRIDE |=> hotplug_q == $past(reg_wdata[NFANS-1:0]))
		else $error("hot-plug override lost");
	a_bit2_reset: assert property (@(posedge mclk) disable iff (rst) // see RL3
		$fell(rst) |-> pin_use_q[2])
		else $error("pin use bit 2 reset wrong");
	a_sense_hold_b: assert property (@(posedge mclk) disable iff (rst) // see RL8
		det_q == FGRC_DET_DONE |=> $stable(remote_sensor_b_present_q))
		else $error("second detection changed after power-up");
	a_unmapped_zero: assert property (@(posedge mclk) disable iff (rst) // see RL6
		reg_rd && (reg_addr < OFS_PIN_CAPABILITY || reg_addr > OFS_FULL_SPEED_OVERRIDE)
		|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* verif/fgrc_host_model.sv */
`default_nettype none
module fgrc_host_model
(
	// Bus clock
	input wire logic mclk,
	// Requests
	output var logic reg_wr,
	output var logic reg_rd,
	output var logic [7:0] reg_addr,
	output var logic [7:0] reg_wdata,
	// Answer
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Released data shows a changed pattern so a stale byte never passes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

/* verif/fgrc_regs_tb_top.sv */
`default_nettype none
module fgrc_regs_tb_top
	import fgrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [7:0] a;
		logic [7:0] w;
		logic [7:0] e;
		logic m;
		logic [1:0] p;
		logic [3:0] s;
	} fgrc_row_type;
	logic mclk, rst, d1, d2, mon;
	logic [1:0] prio;
	logic [3:0] fan_speed;
	logic [7:0] reg_rdata;
	wire logic reg_wr, reg_rd;
	wire logic [7:0] reg_addr, reg_wdata;
	int failures, checked;
	// Overrides accumulate from row to row
	fgrc_row_type rows [11] = '{
		'{8'h04, 8'h00, 8'h7F, 1'h0, 2'h0, 4'h5},
		'{8'h05, 8'hFF, 8'h7F, 1'h1, 2'h0, 4'h0},
		'{8'h05, 8'h00, 8'h00, 1'h1, 2'h0, 4'h0},
		'{8'h06, 8'h00, 8'h03, 1'h1, 2'h0, 4'h0},
		'{8'h07, 8'hFD, 8'h01, 1'h1, 2'h0, 4'h1},
		'{8'h08, 8'hFE, 8'h02, 1'h1, 2'h0, 4'h9},
		'{8'h08, 8'h03, 8'h03, 1'h1, 2'h1, 4'hA},
		'{8'h08, 8'h03, 8'h03, 1'h1, 2'h0, 4'h9},
		'{8'h09, 8'h02, 8'h02, 1'h1, 2'h0, 4'hD},
		'{8'h07, 8'h00, 8'h00, 1'h0, 2'h0, 4'h5},
		'{8'h0A, 8'hFF, 8'h00, 1'h1, 2'h0, 4'hE}};
	// ==========================================
	// Parts
	fgrc_regs dut_u (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.remote_diode_first(d1), .remote_diode_second(d2), .monitor_start(mon),
		.hotplug_priority(prio), .fan_speed(fan_speed));
	fgrc_host_model host_u (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	// ==========================================
	// Checks
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		host_u.rd(a, v);
		chk8(v, e);
	endtask
	task automatic close_out();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Pins settle long before release so the synchroniser sees them
	task automatic do_reset(input logic f, input logic s);
		@(posedge mclk);
		rst <= 1'h1;
		d1 <= f;
		d2 <= s;
		mon <= 1'h0;
		repeat (20) @(posedge mclk);
		chk4(fan_speed, 4'h5);
		rst <= 1'h0;
		repeat (DETECT_CYCLES + 6) @(posedge mclk);
	endtask
	// ==========================================
	// Sequence
	initial
	begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	initial
	begin
		rst = 1'h1;
		d1 = 1'h0;
		d2 = 1'h0;
		mon = 1'h0;
		prio = 2'h0;
		failures = 0;
		checked = 0;
		do_reset(1'h1, 1'h0);
		rdchk(OFS_PIN_USE_SELECT, 8'h67);
		rdchk(OFS_SENSORS_INSTALLED, 8'h03);
		foreach (rows[i])
		begin
			@(posedge mclk);
			mon <= rows[i].m;
			prio <= rows[i].p;
			host_u.wr(rows[i].a, rows[i].w);
			rdchk(rows[i].a, rows[i].e);
			@(posedge mclk);
			#1;
			chk4(fan_speed, rows[i].s);
		end
		do_reset(1'h0, 1'h1);
		rdchk(OFS_PIN_USE_SELECT, 8'h1F);
		rdchk(OFS_SENSORS_INSTALLED, 8'h05);
		rdchk(OFS_ALARM_SPEED_OVERRIDE, 8'h00);
		rdchk(OFS_HOTPLUG_SPEED_OVERRIDE, 8'h00);
		rdchk(OFS_FULL_SPEED_OVERRIDE, 8'h00);
		host_u.wr(OFS_PIN_USE_SELECT, 8'h5A);
		rdchk(OFS_PIN_USE_SELECT, 8'h5A);
		// Stopped monitoring keeps alarm speed even with full speed requested
		host_u.wr(OFS_FULL_SPEED_OVERRIDE, 8'h01);
		chk8(reg_rdata, 8'h5A);
		@(posedge mclk);
		#1;
		chk4(fan_speed, 4'h5);
		@(posedge mclk);
		mon <= 1'h1;
		@(posedge mclk);
		#1;
		chk4(fan_speed, 4'h3);
		close_out();
	end
	// Whole run is under two hundred cycles
	initial
	begin
		repeat (5000) @(posedge mclk);
		failures++;
		close_out();
	end
endmodule
`default_nettype wire
